/* File: logic/sss_map.svh */
// Offsets, field positions, reset values and timing counts of the
// start-up slot sequencer. Definitions only; included by the sequencer.
`ifndef SSS_MAP_SVH
`define SSS_MAP_SVH

// Clock
`define SSS_CLK_PERIOD_NS 4
`define SSS_NS_PER_US 1000
`define SSS_US_CYCLES (`SSS_NS_PER_US / `SSS_CLK_PERIOD_NS)

// Register byte offsets
`define SSS_OFF_CTRL 8'h00
`define SSS_OFF_STATUS 8'h04
`define SSS_OFF_RAIL_EN 8'h08
`define SSS_OFF_SLOT0 8'h40
`define SSS_OFF_SLOT_LAST 8'h6C

// Control fields
`define SSS_CTRL_PERIOD_LSB 0
`define SSS_CTRL_PROG_BIT 2
`define SSS_CTRL_RESET 3'h1

// Status fields
`define SSS_STAT_BACKUP_BIT 0
`define SSS_STAT_RELEASED_BIT 1
`define SSS_STAT_SLOT_LSB 8
`define SSS_STAT_STATE_LSB 16

// Default configuration
`define SSS_DEF_PERIOD 2'h1
`define SSS_DEF_SLOTS {5'h03, 5'h03, 5'h03, 5'h00, 5'h02, 5'h00, \
    5'h03, 5'h00, 5'h03, 5'h03, 5'h02, 5'h01}

// Times in microseconds
`define SSS_SLOT_US_00 500
`define SSS_SLOT_US_01 1000
`define SSS_SLOT_US_10 2000
`define SSS_SLOT_US_11 4000
`define SSS_FIRST_US_00 2000
`define SSS_FIRST_US_01 2500
`define SSS_FIRST_US_10 4000
`define SSS_FIRST_US_11 7000
`define SSS_RELEASE_US 2000
`define SSS_BACKUP_US_CELL 5000
`define SSS_BACKUP_US_NO_CELL 24000

`endif

/* File: logic/sss_pkg.sv */
// Types shared by the start-up slot sequencer and its bench.
// Needs nothing from its surroundings.
package sss_pkg;
    localparam int SSS_RAILS = 12;

    typedef logic [4:0] sss_slot_type;

    typedef enum logic [2:0] {
        ST_BOOT,
        ST_OFF,
        ST_FIRST,
        ST_STEP,
        ST_RELEASE,
        ST_ON
    } sss_state_type;

    typedef struct packed {
        logic prog_sel;
        logic [1:0] period;
    } sss_ctrl_type;

    typedef struct packed {
        logic [7:0] adr;
        logic we;
        logic [3:0] sel;
        logic [31:0] dat;
    } sss_wb_req_type;
endpackage

/* File: logic/sss_sequencer.sv */
// Start-up slot sequencer: backup rail delay, slotted rail enables and
// open-drain host reset release, with a classic Wishbone register slave.
// Assumes rst_i is the main-supply-valid power-on reset, pins synchronous.
//
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "sss_map.svh"

module sss_sequencer #(
    parameter int US_CYCLES = `SSS_US_CYCLES
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Power events
    input wire logic coin_cell_valid_i,
    input wire logic turn_on_i,
    input wire logic turn_off_i,
    // Rails and host reset
    output logic backup_rail_en_o,
    output logic [sss_pkg::SSS_RAILS-1:0] rail_en_o,
    output logic host_reset_out_o,
    output logic host_reset_oe_n_o
);
    import sss_pkg::*;

    localparam logic [SSS_RAILS*5-1:0] DEF_SLOTS = `SSS_DEF_SLOTS;
    localparam int PRE_W = $clog2(US_CYCLES + 1);
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(US_CYCLES - 1);
    localparam logic [14:0] SLOT_US [4] = '{15'(`SSS_SLOT_US_00),
        15'(`SSS_SLOT_US_01), 15'(`SSS_SLOT_US_10), 15'(`SSS_SLOT_US_11)};
    localparam logic [14:0] FIRST_US [4] = '{15'(`SSS_FIRST_US_00),
        15'(`SSS_FIRST_US_01), 15'(`SSS_FIRST_US_10), 15'(`SSS_FIRST_US_11)};

    // Register state
    sss_ctrl_type ctrl_q, ctrl_d;
    sss_slot_type slot_q [SSS_RAILS];
    sss_slot_type slot_d [SSS_RAILS];
    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;

    // Sequencer state
    sss_state_type state_q, state_d;
    logic [PRE_W-1:0] pre_q, pre_d;
    logic [14:0] us_q, us_d;
    sss_slot_type cur_q, cur_d;
    logic [SSS_RAILS-1:0] en_q, en_d;
    logic backup_q, backup_d;
    logic released_q, released_d;
    logic cell_q, cell_d;
    logic boot_q, boot_d;

    // Effective configuration
    sss_slot_type eff_slot [SSS_RAILS];
    logic [1:0] eff_period;
    sss_slot_type max_slot;
    logic [14:0] slot_us, first_us, backup_us;
    logic tick;
    logic wb_req;
    sss_wb_req_type req;

    assign req = '{adr: wb_adr_i, we: wb_we_i, sel: wb_sel_i,
                   dat: wb_dat_i};
    assign wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    assign tick = (pre_q == PRE_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < SSS_RAILS; gi++) begin : g_rail
            // Fixed slots unless the programmed set is selected
            assign eff_slot[gi] = ctrl_q.prog_sel ? slot_q[gi] :
                DEF_SLOTS[gi*5 +: 5];
        end
    endgenerate

    assign eff_period = ctrl_q.prog_sel ? ctrl_q.period : `SSS_DEF_PERIOD;

    always_comb begin
        max_slot = '0;
        for (int i = 0; i < SSS_RAILS; i++) begin
            if (eff_slot[i] > max_slot) begin
                max_slot = eff_slot[i];
            end
        end
        slot_us = SLOT_US[eff_period];
        first_us = FIRST_US[eff_period];
        // Longer wait while the coin cell is absent
        backup_us = cell_q ? 15'(`SSS_BACKUP_US_CELL) :
            15'(`SSS_BACKUP_US_NO_CELL);
    end

    // Register file: next values
    always_comb begin
        ctrl_d = ctrl_q;
        slot_d = slot_q;
        ack_d = wb_req;
        rdat_d = '0;
        if (wb_req && req.we && req.sel[0]) begin
            if (req.adr == `SSS_OFF_CTRL) begin
                ctrl_d.period = req.dat[`SSS_CTRL_PERIOD_LSB +: 2];
                ctrl_d.prog_sel = req.dat[`SSS_CTRL_PROG_BIT];
            end
            for (int i = 0; i < SSS_RAILS; i++) begin
                if (req.adr == 8'(`SSS_OFF_SLOT0 + 4 * i)) begin
                    slot_d[i] = req.dat[4:0];
                end
            end
        end
        if (wb_req && !req.we) begin
            case (req.adr)
                `SSS_OFF_CTRL: begin
                    rdat_d[`SSS_CTRL_PERIOD_LSB +: 2] = ctrl_q.period;
                    rdat_d[`SSS_CTRL_PROG_BIT] = ctrl_q.prog_sel;
                end
                `SSS_OFF_STATUS: begin
                    rdat_d[`SSS_STAT_BACKUP_BIT] = backup_q;
                    rdat_d[`SSS_STAT_RELEASED_BIT] = released_q;
                    rdat_d[`SSS_STAT_SLOT_LSB +: 5] = cur_q;
                    rdat_d[`SSS_STAT_STATE_LSB +: 3] = state_q;
                end
                `SSS_OFF_RAIL_EN: begin
                    rdat_d[SSS_RAILS-1:0] = en_q;
                end
                default: begin
                    for (int i = 0; i < SSS_RAILS; i++) begin
                        if (req.adr == 8'(`SSS_OFF_SLOT0 + 4 * i)) begin
                            rdat_d[4:0] = slot_q[i];
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_q <= `SSS_CTRL_RESET;
            for (int i = 0; i < SSS_RAILS; i++) begin
                slot_q[i] <= DEF_SLOTS[i*5 +: 5];
            end
            ack_q <= 1'b0;
            rdat_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            slot_q <= slot_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    // Sequencer: next values
    always_comb begin
        state_d = state_q;
        cur_d = cur_q;
        backup_d = backup_q;
        released_d = released_q;
        boot_d = 1'b0;
        // Coin cell sampled one cycle after reset release
        cell_d = boot_q ? coin_cell_valid_i : cell_q;
        pre_d = tick ? '0 : pre_q + 1'b1;
        us_d = tick ? us_q + 1'b1 : us_q;
        case (state_q)
            ST_BOOT: begin
                if (!boot_q && tick && us_q == backup_us - 1'b1) begin
                    backup_d = 1'b1;
                    state_d = ST_OFF;
                end
            end
            ST_OFF: begin
                if (turn_on_i && !turn_off_i) begin
                    state_d = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (tick && us_q == first_us - 1'b1) begin
                    cur_d = 5'h01;
                    state_d = (max_slot <= 5'h01) ? ST_RELEASE : ST_STEP;
                end
            end
            ST_STEP: begin
                if (tick && us_q == slot_us - 1'b1) begin
                    cur_d = cur_q + 1'b1;
                    if (cur_d >= max_slot) begin
                        state_d = ST_RELEASE;
                    end
                end
            end
            ST_RELEASE: begin
                if (tick && us_q == 15'(`SSS_RELEASE_US) - 1'b1) begin
                    released_d = 1'b1;
                    state_d = ST_ON;
                end
            end
            ST_ON: begin
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase
        // A turn-off pulls the rails and host reset back down; the backup rail stays on
        if (turn_off_i && state_q != ST_BOOT) begin
            state_d = ST_OFF;
            cur_d = '0;
            released_d = 1'b0;
        end
        // Counters restart at each state or slot change so waits are whole
        if (state_d != state_q || cur_d != cur_q) begin
            us_d = '0;
            pre_d = '0;
        end
        for (int i = 0; i < SSS_RAILS; i++) begin
            en_d[i] = eff_slot[i] != '0 && cur_d != '0 &&
                eff_slot[i] <= cur_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= ST_BOOT;
            cur_q <= '0;
            backup_q <= 1'b0;
            released_q <= 1'b0;
            cell_q <= 1'b0;
            boot_q <= 1'b1;
            pre_q <= '0;
            us_q <= '0;
            en_q <= '0;
        end else begin
            state_q <= state_d;
            cur_q <= cur_d;
            backup_q <= backup_d;
            released_q <= released_d;
            cell_q <= cell_d;
            boot_q <= boot_d;
            pre_q <= pre_d;
            us_q <= us_d;
            en_q <= en_d;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdat_q;
    assign backup_rail_en_o = backup_q;
    assign rail_en_o = en_q;
    assign host_reset_out_o = 1'b0;
    // Open drain: enable low pulls the line low
    assign host_reset_oe_n_o = released_q;

    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_default_cfg;
        !ctrl_q.prog_sel |-> eff_slot[0] == 5'h01 && eff_slot[4] == 5'h00
            && eff_period == 2'h1;
    endproperty
    a_default_cfg: assert property (p_default_cfg)
        else $error("default configuration not applied");
    property p_first_wait;
        state_q == ST_OFF && state_d == ST_FIRST ##1
            (state_q == ST_FIRST)[*8] |-> cur_q == 5'h00;
    endproperty
    a_first_wait: assert property (p_first_wait)
        else $error("first rail enabled too early");
    property p_first_slot;
        $rose(cur_q == 5'h01) && $past(state_q) == ST_FIRST |->
            $past(us_q) == first_us - 1'b1 && $past(tick);
    endproperty
    a_first_slot: assert property (p_first_slot)
        else $error("first rail wait wrong");
    property p_period_reset;
        $past(rst_i) |-> ctrl_q.period == 2'h1 && !ctrl_q.prog_sel;
    endproperty
    a_period_reset: assert property (p_period_reset)
        else $error("slot period select reset wrong");
    property p_release;
        $rose(host_reset_oe_n_o) |-> $past(state_q) == ST_RELEASE &&
            $past(us_q) == 15'(`SSS_RELEASE_US) - 1'b1;
    endproperty
    a_release: assert property (p_release)
        else $error("host reset released at wrong time");
    property p_reassert;
        $fell(host_reset_oe_n_o) |-> $past(turn_off_i);
    endproperty
    a_reassert: assert property (p_reassert)
        else $error("host reset asserted without turn-off");
    property p_backup;
        $rose(backup_rail_en_o) |-> $past(us_q) == backup_us - 1'b1;
    endproperty
    a_backup: assert property (p_backup)
        else $error("backup rail delay wrong");
    property p_slot_reset;
        $past(rst_i) |-> slot_q[0] == 5'h01 && slot_q[1] == 5'h02 &&
            slot_q[5] == 5'h03 && slot_q[6] == 5'h00;
    endproperty
    a_slot_reset: assert property (p_slot_reset)
        else $error("slot fields reset wrong");
    property p_zero_off;
        eff_slot[4] == 5'h00 && $stable(eff_slot[4]) |-> !en_q[4];
    endproperty
    a_zero_off: assert property (p_zero_off)
        else $error("rail with slot zero enabled");
    property p_step;
        state_q == ST_STEP && cur_d != cur_q && !turn_off_i |->
            us_q == slot_us - 1'b1 && tick;
    endproperty
    a_step: assert property (p_step)
        else $error("slot spacing wrong");
    property p_stop;
        state_q == ST_STEP |-> cur_q < max_slot;
    endproperty
    a_stop: assert property (p_stop)
        else $error("stepping past last slot");

    c_backup: cover property ($rose(backup_rail_en_o));
    c_release: cover property ($rose(host_reset_oe_n_o));
    c_turn_off: cover property ($fell(host_reset_oe_n_o));
endmodule

/* File: dv/sss_host_model.sv */
// Processor side of the open-drain host reset line.
// Assumes a board pull-up; the sequencer only ever pulls the line low.
`timescale 1ns/1ps
module sss_host_model (
    // Open-drain pin from the sequencer
    input wire logic drive_i,
    input wire logic oe_n_i,
    // Level seen by the processor
    output logic line_o
);
    // Released pin floats to the pull-up, never to the last driven value
    assign line_o = oe_n_i ? 1'b1 : drive_i;
endmodule

/* File: dv/sss_tb.sv */
// Self-checking bench for the start-up slot sequencer.
// Assumes the sequencer package and map header; US_CYCLES shortened to 2.
`timescale 1ns/1ps
module tb;
    import sss_pkg::*;
    localparam int USC = 2;
    localparam int FU [4] = '{2000, 2500, 4000, 7000};
    localparam int SU [4] = '{500, 1000, 2000, 4000};
    localparam logic [4:0] DSL [12] = '{5'h01, 5'h02, 5'h03, 5'h03, 5'h00,
        5'h03, 5'h00, 5'h02, 5'h00, 5'h03, 5'h03, 5'h03};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic coin_cell_valid_i = 1'b1;
    logic turn_on_i = 1'b0;
    logic turn_off_i = 1'b0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic backup_rail_en_o;
    logic [SSS_RAILS-1:0] rail_en_o;
    logic host_reset_out_o;
    logic host_reset_oe_n_o;
    logic host_line;
    logic bk2;
    logic [31:0] rd;
    int fails = 0;
    int tests_run = 0;
    int cnt = 0;
    always #2 clk_i = ~clk_i;
    always @(posedge clk_i) cnt <= cnt + 1;
    sss_sequencer #(.US_CYCLES(USC)) dut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .coin_cell_valid_i(coin_cell_valid_i), .turn_on_i(turn_on_i),
        .turn_off_i(turn_off_i), .backup_rail_en_o(backup_rail_en_o),
        .rail_en_o(rail_en_o), .host_reset_out_o(host_reset_out_o),
        .host_reset_oe_n_o(host_reset_oe_n_o));
    // Second part without a coin cell, only its backup delay is watched
    sss_sequencer #(.US_CYCLES(USC)) dut2 (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(), .wb_ack_o(), .coin_cell_valid_i(1'b0),
        .turn_on_i(turn_on_i), .turn_off_i(turn_off_i),
        .backup_rail_en_o(bk2),
        .rail_en_o(), .host_reset_out_o(), .host_reset_oe_n_o());
    sss_host_model host (.drive_i(host_reset_out_o),
        .oe_n_i(host_reset_oe_n_o), .line_o(host_line));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        tests_run++;
        if (got < lo || got > hi) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] adr,
        input logic [31:0] dat, input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
        if (n >= 50) chk(32'h0, 32'h1);
    endtask
    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0, 4'hF);
        chk(rd, exp);
    endtask
    // Bounded wait for a rail, the host line (12), backup (13), dut2 (14)
    task automatic wait_hi(input int k, output int t);
        int n;
        logic s;
        n = 0;
        s = 1'b0;
        while (s !== 1'b1 && n < 60000) begin
            @(posedge clk_i);
            #1;
            n++;
            s = (k == 12) ? host_line : (k == 13) ? backup_rail_en_o :
                (k == 14) ? bk2 : rail_en_o[k];
        end
        t = cnt;
        if (n >= 60000) chk(32'h0, 32'h1);
    endtask
    task automatic pulse(input logic on, output int t);
        @(posedge clk_i);
        if (on) turn_on_i <= 1'b1;
        else turn_off_i <= 1'b1;
        t = cnt;
        @(posedge clk_i);
        turn_on_i <= 1'b0;
        turn_off_i <= 1'b0;
    endtask
    // Turn on, then time each slot and the host reset release
    task automatic seq(input int f, input int ns, input int ix [3],
        input logic [11:0] m [3]);
        int t0, t1, t;
        pulse(1'b1, t0);
        for (int i = 0; i < ns; i++) begin
            wait_hi(ix[i], t);
            if (i == 0) chk_rng(t - t0, FU[f] * USC, FU[f] * USC + 4);
            else chk_rng(t - t1, SU[f] * USC, SU[f] * USC + 1);
            chk(32'(rail_en_o), 32'(m[i]));
            chk(32'(host_line), 32'h0);
            t1 = t;
        end
        wait_hi(12, t);
        chk_rng(t - t1, 2000 * USC, 2000 * USC + 1);
        chk(32'(rail_en_o), 32'(m[ns - 1]));
    endtask

    initial begin
        int t;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_hi(14, t);
        chk_rng(t, 48000, 48012);
    end
    initial begin
        repeat (100000) @(posedge clk_i);
        fails++;
        wrap_up();
    end
    initial begin
        int t, t_rst;
        repeat (6) @(posedge clk_i);
        t_rst = cnt;
        rdc(8'h00, 32'h1);
        for (int i = 0; i < 12; i++) begin
            rdc(8'h40 + 8'(4 * i), 32'(DSL[i]));
        end
        rdc(8'h08, 32'h0);
        rdc(8'h30, 32'h0);
        chk(32'(host_line), 32'h0);
        $display("test reset values done");
        wait_hi(13, t);
        chk_rng(t - t_rst, 5000 * USC, 5000 * USC + 4);
        $display("test backup delay done");
        seq(1, 3, '{0, 1, 2}, '{12'h001, 12'h083, 12'hEAF});
        wb(1'b0, 8'h04, 32'h0, 4'hF);
        chk(rd & 32'h00070003, 32'h00050003);
        pulse(1'b1, t);
        repeat (200) @(posedge clk_i);
        chk(32'(host_line), 32'h1);
        chk(32'(rail_en_o), 32'hEAF);
        pulse(1'b0, t);
        @(posedge clk_i);
        #1;
        chk(32'(rail_en_o), 32'h0);
        chk(32'(host_line), 32'h0);
        $display("test default sequence done");
        // Programmed: rail 0 in slot 1, memory reference in slot 2
        for (int i = 0; i < 12; i++) begin
            wb(1'b1, 8'h40 + 8'(4 * i), (i == 0) ? 32'h1 : (i == 5) ? 32'h2 :
                32'h0, 4'hF);
        end
        wb(1'b1, 8'h44, 32'h1F, 4'h0);
        rdc(8'h44, 32'h0);
        for (int p = 0; p < 4; p++) begin
            if (p != 1) begin
                wb(1'b1, 8'h00, 32'h4 | 32'(p), 4'hF);
                rdc(8'h00, 32'h4 | 32'(p));
                seq(p, 2, '{0, 5, 0},
                    '{12'h001, 12'h021, 12'h021});
                pulse(1'b0, t);
                repeat (2) @(posedge clk_i);
            end
        end
        $display("test programmed periods done");
        wrap_up();
    end
endmodule
